// ==== design/vic_ctrl.sv ====
// eight-level vectored interrupt unit with AHB-Lite register slave
// What this block does
// - fast line to the core follows only source 0 (fast input or set command), while enabled and not spurious
// - standard line serves software, peripheral and three external requests
// - internal sources level or edge; external rising, falling, high or low
// - sources: 0 fast, 1 software, 2-8 peripherals, 16-18 external
// - reserved sources do nothing and their registers read zero
// - standard vector read returns handler of highest pending source
// - each standard source has a three-bit priority, seven highest
// - highest priority wins, ties go to lowest source number
// - current level latched from winner when the vector is taken
// - a newer higher request before the read is what the read returns
// - higher request reasserts line; next read pushes level onto stack
// - end-of-service write pops the previous level if one is stacked
// - vector read drops the line and clears an edge source
// - enable and disable commands set the mask, which reads back
// - disabled sources never affect arbitration of enabled ones
// - set and clear commands force pending of edge sources
// - fast path skips the encoder, uses source 0 mode and vector
// - fast vector read returns source 0 vector while fast raised
// - read with nothing eligible returns the spurious vector
// - protect mode: only a vector write stacks and acknowledges
`timescale 1ns/1ns
module vic_ctrl
  import vic_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic fast_request_input,
  input wire logic [2:0] external_request,
  input wire vic_periph_t periph_sources,
  output logic fast_request_to_core,
  output logic standard_request_to_core
);

  // ************************************************************
  // bus front end
  // ************************************************************
  logic take;
  logic rd_go;
  logic wr_pend_q;
  logic [8:0] wr_addr_q;
  logic [8:0] rd_addr;
  logic wr_go;
  logic [31:0] hrdata_q;
  logic [31:0] rd_data;
  assign take = hsel && htrans[1] && hready;
  assign rd_go = take && !hwrite;
  assign rd_addr = haddr[8:0];
  assign wr_go = wr_pend_q;
  // a read straight after a write waits one cycle so it sees the write
  assign hreadyout = !(wr_pend_q && hsel && htrans[1] && !hwrite);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 9'h000;
    end else begin
      wr_pend_q <= take && hwrite;
      if (take && hwrite) begin
        wr_addr_q <= haddr[8:0];
      end
    end
  end

  logic wr_std_vec;
  logic wr_eos;
  logic wr_set;
  logic wr_clr;
  logic rd_std_vec;
  logic rd_fast_vec;
  assign wr_std_vec = wr_go && (wr_addr_q == VIC_OFS_STD_VEC);
  assign wr_eos = wr_go && (wr_addr_q == VIC_OFS_EOS);
  assign wr_set = wr_go && (wr_addr_q == VIC_OFS_SET);
  assign wr_clr = wr_go && (wr_addr_q == VIC_OFS_CLEAR);
  assign rd_std_vec = rd_go && (rd_addr == VIC_OFS_STD_VEC);
  assign rd_fast_vec = rd_go && (rd_addr == VIC_OFS_FAST_VEC);

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [2:0] prio_q [VIC_NSRC];
  logic [1:0] type_q [VIC_NSRC];
  logic [31:0] vec_q [VIC_NSRC];
  logic [31:0] mask_q;
  logic [31:0] spu_q;
  logic prot_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < VIC_NSRC; i++) begin
        prio_q[i] <= VIC_PRIO_RST;
        type_q[i] <= VIC_TYPE_RST;
        vec_q[i] <= VIC_VEC_RST;
      end
    end else if (wr_go && !wr_addr_q[8] && VIC_VALID_SRC[wr_addr_q[6:2]]) begin
      if (!wr_addr_q[7]) begin
        prio_q[wr_addr_q[6:2]] <= hwdata[VIC_PRIO_LSB +: 3];
        type_q[wr_addr_q[6:2]] <= hwdata[VIC_TYPE_LSB +: 2];
      end else begin
        vec_q[wr_addr_q[6:2]] <= hwdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= VIC_WORD_ZERO;
    end else if (wr_go && wr_addr_q == VIC_OFS_ENABLE) begin
      mask_q <= mask_q | (hwdata & VIC_VALID_SRC);
    end else if (wr_go && wr_addr_q == VIC_OFS_DISABLE) begin
      mask_q <= mask_q & ~hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spu_q <= VIC_WORD_ZERO;
      prot_q <= 1'b0;
    end else if (wr_go && wr_addr_q == VIC_OFS_SPURIOUS) begin
      spu_q <= hwdata;
    end else if (wr_go && wr_addr_q == VIC_OFS_PROTECT) begin
      prot_q <= hwdata[VIC_PROT_BIT];
    end
  end

  // ************************************************************
  // source inputs and pending state
  // ************************************************************
  logic [VIC_NPIN-1:0] pin_raw;
  logic [VIC_NPIN-1:0] pin_lvl;
  logic [31:0] src_in;
  logic [31:0] pend;
  logic [31:0] elig;
  logic [31:0] ack_clr;
  logic cur_valid_q;
  logic [2:0] cur_level_q;
  logic spurious_q;
  logic fast_raised;

  assign pin_raw = {external_request, fast_request_input};

  genvar p;
  generate
    for (p = 0; p < VIC_NPIN; p++) begin : g_pin
      vic_pin_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(pin_raw[p]),
        .level_q(pin_lvl[p])
      );
    end
  endgenerate

  assign src_in = {13'h0000, pin_lvl[3:1], 7'h00, periph_sources, 1'b0, pin_lvl[0]};

  genvar g;
  generate
    for (g = 0; g < VIC_NSRC; g++) begin : g_src
      logic act;
      logic prev_q;
      logic pend_q;
      logic edge_mode;
      // external sources may be active low; internal are always active high
      assign act = (VIC_EXT_SRC[g] && !type_q[g][VIC_TYPE_HIGH]) ? !src_in[g] : src_in[g];
      assign edge_mode = type_q[g][VIC_TYPE_EDGE];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          prev_q <= 1'b0;
          pend_q <= 1'b0;
        end else begin
          prev_q <= act;
          if (!edge_mode) begin
            pend_q <= 1'b0;
          end else if ((act && !prev_q) || (wr_set && hwdata[g])) begin
            pend_q <= 1'b1;
          end else if ((wr_clr && hwdata[g]) || ack_clr[g]) begin
            pend_q <= 1'b0;
          end
        end
      end
      assign pend[g] = VIC_VALID_SRC[g] && (edge_mode ? pend_q : act);
      // masked sources and the fast source never reach the encoder
      assign elig[g] = (g != 0) && pend[g] && mask_q[g] &&
                       (!cur_valid_q || (prio_q[g] > cur_level_q));
    end
  endgenerate

  // ************************************************************
  // priority encoder
  // ************************************************************
  vic_pick_t win;
  logic [31:0] win_vec;
  always_comb begin
    win = '0;
    for (int i = VIC_NSRC - 1; i >= 0; i--) begin
      // descending scan with >= leaves the lowest number among equals
      if (elig[i] && (!win.ok || prio_q[i] >= win.prio)) begin
        win.idx = 5'(i);
        win.prio = prio_q[i];
        win.ok = 1'b1;
      end
    end
  end

  assign win_vec = win.ok ? vec_q[win.idx] : spu_q;

  // ************************************************************
  // acknowledge, nesting stack and spurious state
  // ************************************************************
  vic_pick_t memo_q;
  vic_pick_t ack;
  logic ack_go;
  logic [2:0] stk_q [VIC_STACK_DEPTH];
  logic [3:0] sp_q;
  logic [4:0] isr_q;

  assign ack_go = prot_q ? wr_std_vec : rd_std_vec;
  assign ack = prot_q ? memo_q : win;
  generate
    for (g = 0; g < VIC_NSRC; g++) begin : g_clr
      assign ack_clr[g] = (ack_go && ack.ok && ack.idx == 5'(g)) ||
                          ((g == 0) && rd_fast_vec && fast_raised);
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      memo_q <= '0;
    end else if (rd_std_vec) begin
      memo_q <= win;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < VIC_STACK_DEPTH; i++) begin
        stk_q[i] <= VIC_PRIO_RST;
      end
      sp_q <= 4'h0;
      cur_valid_q <= 1'b0;
      cur_level_q <= VIC_PRIO_RST;
      isr_q <= 5'h00;
    end else if (ack_go && ack.ok) begin
      if (cur_valid_q) begin
        stk_q[sp_q[2:0]] <= cur_level_q;
        sp_q <= sp_q + 4'h1;
      end
      cur_valid_q <= 1'b1;
      cur_level_q <= ack.prio;
      isr_q <= ack.idx;
    end else if (wr_eos && !spurious_q) begin
      if (sp_q != 4'h0) begin
        cur_level_q <= stk_q[sp_q[2:0] - 3'h1];
        sp_q <= sp_q - 4'h1;
      end else begin
        cur_valid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spurious_q <= 1'b0;
    end else if (ack_go && !ack.ok) begin
      spurious_q <= 1'b1;
    end else if (wr_eos) begin
      spurious_q <= 1'b0;
    end
  end

  // ************************************************************
  // core request lines and read data
  // ************************************************************
  assign fast_raised = pend[0] && mask_q[0];
  assign fast_request_to_core = fast_raised && !spurious_q;
  assign standard_request_to_core = win.ok && !spurious_q;

  always_comb begin
    rd_data = VIC_WORD_ZERO;
    if (!rd_addr[8]) begin
      if (VIC_VALID_SRC[rd_addr[6:2]]) begin
        if (!rd_addr[7]) begin
          rd_data = {25'h0000000, type_q[rd_addr[6:2]], 2'h0, prio_q[rd_addr[6:2]]};
        end else begin
          rd_data = vec_q[rd_addr[6:2]];
        end
      end
    end else begin
      case (rd_addr)
        VIC_OFS_STD_VEC: rd_data = win_vec;
        VIC_OFS_FAST_VEC: rd_data = fast_raised ? vec_q[0] : spu_q;
        VIC_OFS_STATUS: rd_data = {27'h0000000, isr_q};
        VIC_OFS_PENDING: rd_data = pend;
        VIC_OFS_MASK: rd_data = mask_q;
        VIC_OFS_CORE_STAT: rd_data = {30'h00000000, standard_request_to_core,
                                      fast_request_to_core};
        VIC_OFS_SPURIOUS: rd_data = spu_q;
        VIC_OFS_PROTECT: rd_data = {31'h00000000, prot_q};
        default: rd_data = VIC_WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= VIC_WORD_ZERO;
    end else if (rd_go) begin
      hrdata_q <= rd_data;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_fast_needs_mask: assert property (!mask_q[0] |-> !fast_request_to_core)
    else $error("fast line raised while source 0 disabled");
  a_std_vec_data: assert property (rd_std_vec && win.ok |=> hrdata == $past(win_vec))
    else $error("standard vector read returned wrong handler");
  a_spurious_data: assert property (rd_std_vec && !win.ok |=> hrdata == $past(spu_q))
    else $error("spurious vector not returned");
  a_level_latch: assert property (rd_std_vec && !prot_q && win.ok |=>
    cur_level_q == $past(win.prio) && cur_valid_q)
    else $error("current level not taken from winner");
  a_stack_push: assert property (ack_go && ack.ok && cur_valid_q |=>
    sp_q == $past(sp_q) + 4'h1)
    else $error("nested acknowledge did not push");
  a_stack_pop: assert property (wr_eos && !spurious_q && sp_q != 4'h0 && !ack_go |=>
    sp_q == $past(sp_q) - 4'h1)
    else $error("end of service did not pop");
  a_masked_out: assert property ((elig & ~mask_q) == 32'h0000_0000)
    else $error("disabled source is eligible");
  a_set_edge: assert property (wr_set && hwdata[1] && type_q[1][VIC_TYPE_EDGE] |=> pend[1])
    else $error("set command did not raise pending");
  a_protect_read: assert property (rd_std_vec && prot_q |=>
    $stable(sp_q) && $stable(cur_level_q) && $stable(isr_q))
    else $error("protect mode read changed context");
  a_reserved_zero: assert property (!pend[31] && !pend[9] && !pend[19])
    else $error("reserved source pending");

  c_nested: cover property (ack_go && ack.ok && cur_valid_q);
  c_spurious: cover property (ack_go && !ack.ok);
  c_fast: cover property (fast_request_to_core ##1 rd_fast_vec);
  c_pop: cover property (wr_eos && sp_q != 4'h0);

endmodule // vic_ctrl

// ==== design/vic_pin_sync.sv ====
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module vic_pin_sync
  import vic_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  output logic level_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

endmodule // vic_pin_sync

// ==== design/vic_pkg.sv ====
// constants, field layouts and carrier types of the vectored interrupt unit
package vic_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam int VIC_ADDR_W = 9;
  localparam logic [8:0] VIC_OFS_MODE_BASE = 9'h000;
  localparam logic [8:0] VIC_OFS_VEC_BASE = 9'h080;
  localparam logic [8:0] VIC_OFS_STD_VEC = 9'h100;
  localparam logic [8:0] VIC_OFS_FAST_VEC = 9'h104;
  localparam logic [8:0] VIC_OFS_STATUS = 9'h108;
  localparam logic [8:0] VIC_OFS_PENDING = 9'h10C;
  localparam logic [8:0] VIC_OFS_MASK = 9'h110;
  localparam logic [8:0] VIC_OFS_CORE_STAT = 9'h114;
  localparam logic [8:0] VIC_OFS_ENABLE = 9'h120;
  localparam logic [8:0] VIC_OFS_DISABLE = 9'h124;
  localparam logic [8:0] VIC_OFS_CLEAR = 9'h128;
  localparam logic [8:0] VIC_OFS_SET = 9'h12C;
  localparam logic [8:0] VIC_OFS_EOS = 9'h130;
  localparam logic [8:0] VIC_OFS_SPURIOUS = 9'h134;
  localparam logic [8:0] VIC_OFS_PROTECT = 9'h138;

  // ************************************************************
  // source map and mode field layout
  // ************************************************************
  localparam int VIC_NSRC = 32;
  localparam int VIC_NPIN = 4;
  localparam int VIC_STACK_DEPTH = 8;
  localparam logic [31:0] VIC_VALID_SRC = 32'h0007_01FF;
  localparam logic [31:0] VIC_EXT_SRC = 32'h0007_0001;
  localparam int VIC_PRIO_LSB = 0;
  localparam int VIC_TYPE_LSB = 5;
  localparam int VIC_PROT_BIT = 0;
  // type bit 0: edge triggered; bit 1: active high / rising (external only)
  localparam int VIC_TYPE_EDGE = 0;
  localparam int VIC_TYPE_HIGH = 1;
  localparam logic [2:0] VIC_PRIO_RST = 3'h0;
  localparam logic [1:0] VIC_TYPE_RST = 2'h0;
  localparam logic [31:0] VIC_VEC_RST = 32'h0000_0000;
  localparam logic [31:0] VIC_WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] VIC_HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic parallel_io_source;
    logic watchdog_source;
    logic timer2_source;
    logic timer1_source;
    logic timer0_source;
    logic serial1_source;
    logic serial0_source;
  } vic_periph_t;

  typedef struct packed {
    logic [2:0] prio;
    logic [4:0] idx;
    logic ok;
  } vic_pick_t;

endpackage

// ==== verif/vic_core_model.sv ====
// processor core stand-in that counts assertions of the two request lines
`timescale 1ns/1ns
module vic_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic fast_line,
  input wire logic std_line,
  output int fast_cnt,
  output int std_cnt
);
  logic fast_q;
  logic std_q;
  // level requests: only a rising edge is a new request to the core
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_q <= 1'b0;
      std_q <= 1'b0;
      fast_cnt <= 0;
      std_cnt <= 0;
    end else begin
      fast_q <= fast_line;
      std_q <= std_line;
      if (fast_line && !fast_q) fast_cnt <= fast_cnt + 1;
      if (std_line && !std_q) std_cnt <= std_cnt + 1;
    end
  end
endmodule // vic_core_model

// ==== verif/vic_ctrl_tb.sv ====
// self-checking bench of the vectored interrupt unit
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module vic_ctrl_tb;
  import vic_pkg::*;
  typedef struct {logic [8:0] wa; logic [31:0] wd; logic [8:0] ra; logic [31:0] ex;} vic_row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, fin, fout, sout;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, ext;
  vic_periph_t per;
  int fail_count, comparisons, fast_cnt, std_cnt;
  vic_row_t rows[8] = '{
    '{9'h008, 32'h0000_0023, 9'h008, 32'h0000_0023},
    '{9'h088, 32'h0000_1234, 9'h088, 32'h0000_1234},
    '{9'h024, 32'h0000_0027, 9'h024, 32'h0000_0000},
    '{9'h0D0, 32'h0000_FFFF, 9'h0D0, 32'h0000_0000},
    '{VIC_OFS_SPURIOUS, 32'h0000_DEAD, VIC_OFS_SPURIOUS, 32'h0000_DEAD},
    '{VIC_OFS_ENABLE, 32'hFFFF_FFFF, VIC_OFS_MASK, VIC_VALID_SRC},
    '{VIC_OFS_DISABLE, 32'hFFFF_FFFF, VIC_OFS_MASK, 32'h0000_0000},
    '{VIC_OFS_ENABLE, 32'hFFFF_FFFF, VIC_OFS_MASK, VIC_VALID_SRC}};

  vic_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fast_request_input(fin),
    .external_request(ext), .periph_sources(per), .fast_request_to_core(fout),
    .standard_request_to_core(sout));
  vic_core_model core (.hclk(hclk), .hresetn(hresetn), .fast_line(fout), .std_line(sout),
    .fast_cnt(fast_cnt), .std_cnt(std_cnt));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // ************************************************************
  // bus and check tasks
  // ************************************************************
  function automatic logic [31:0] ev(input int i);
    return 32'h0000_0100 + 32'(i);
  endfunction

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic hold(output logic [31:0] q);
    int n;
    logic r;
    n = 0;
    r = 1'b0;
    while (!r) begin
      @(negedge hclk);
      r = hreadyout;
      q = hrdata;
      @(posedge hclk);
      n++;
      if (n > 50) begin
        fail_count++;
        results();
      end
    end
  endtask

  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {23'h0, a};
    htrans <= VIC_HTRANS_NONSEQ;
    hwrite <= w;
    hold(rd);
    htrans <= 2'h0;
    hwdata <= d;
    hold(rd);
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [8:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK("read", e, rd)
    `CHK("response", 1'b0, hresp)
  endtask

  task automatic lines(input logic s, input logic f);
    @(negedge hclk);
    `CHK("std line", s, sout)
    `CHK("fast line", f, fout)
    @(posedge hclk);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    fin = 1'b1;
    ext = 3'h7;
    per = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    lines(1'b0, 1'b0);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rdc(rows[i].ra, rows[i].ex);
    end
    for (int i = 0; i < 19; i++) if (VIC_VALID_SRC[i]) wr(VIC_OFS_VEC_BASE + 9'(4 * i), ev(i));
    wr(9'h008, 32'h0000_0002);
    wr(9'h010, 32'h0000_0005);
    wr(9'h014, 32'h0000_0005);
    wr(9'h01C, 32'h0000_0006);
    wr(VIC_OFS_DISABLE, 32'h0000_0080);
    per <= 7'h01;
    repeat (3) @(posedge hclk);
    lines(1'b1, 1'b0);
    per <= 7'h0D;
    repeat (3) @(posedge hclk);
    rdc(VIC_OFS_STD_VEC, ev(4));
    rdc(VIC_OFS_STATUS, 32'h0000_0004);
    lines(1'b0, 1'b0);
    per <= 7'h2D;
    repeat (3) @(posedge hclk);
    lines(1'b0, 1'b0);
    wr(VIC_OFS_ENABLE, 32'h0000_0080);
    lines(1'b1, 1'b0);
    rdc(VIC_OFS_STD_VEC, ev(7));
    per <= 7'h0D;
    wr(VIC_OFS_EOS, 32'h0000_0000);
    lines(1'b0, 1'b0);
    wr(VIC_OFS_EOS, 32'h0000_0000);
    lines(1'b1, 1'b0);
    per <= '0;
    repeat (3) @(posedge hclk);
    lines(1'b0, 1'b0);
    wr(VIC_OFS_EOS, 32'h0000_0000);
    // software source, edge triggered before set and clear use
    wr(9'h004, 32'h0000_0023);
    wr(VIC_OFS_SET, 32'h0000_0002);
    lines(1'b1, 1'b0);
    wr(VIC_OFS_CLEAR, 32'h0000_0002);
    lines(1'b0, 1'b0);
    wr(VIC_OFS_SET, 32'h0000_0002);
    rdc(VIC_OFS_STD_VEC, ev(1));
    rdc(VIC_OFS_PENDING, 32'h0000_0000);
    wr(VIC_OFS_EOS, 32'h0000_0000);
    wr(VIC_OFS_PROTECT, 32'h0000_0001);
    wr(VIC_OFS_SET, 32'h0000_0002);
    rdc(VIC_OFS_STD_VEC, ev(1));
    lines(1'b1, 1'b0);
    wr(VIC_OFS_STD_VEC, 32'h0000_0000);
    lines(1'b0, 1'b0);
    wr(VIC_OFS_EOS, 32'h0000_0000);
    wr(VIC_OFS_PROTECT, 32'h0000_0000);
    rdc(VIC_OFS_STD_VEC, 32'h0000_DEAD);
    wr(VIC_OFS_SET, 32'h0000_0002);
    lines(1'b0, 1'b0);
    wr(VIC_OFS_EOS, 32'h0000_0000);
    rdc(VIC_OFS_STD_VEC, ev(1));
    wr(VIC_OFS_EOS, 32'h0000_0000);
    wr(9'h000, 32'h0000_0040);
    repeat (2) @(posedge hclk);
    lines(1'b0, 1'b1);
    rdc(VIC_OFS_FAST_VEC, ev(0));
    wr(9'h000, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    lines(1'b0, 1'b0);
    // external pins already handed to this block
    wr(9'h040, 32'h0000_0024);
    ext <= 3'h6;
    repeat (8) @(posedge hclk);
    lines(1'b1, 1'b0);
    rdc(VIC_OFS_STD_VEC, ev(16));
    wr(VIC_OFS_EOS, 32'h0000_0000);
    wr(9'h044, 32'h0000_0044);
    ext <= 3'h7;
    repeat (8) @(posedge hclk);
    lines(1'b1, 1'b0);
    rdc(VIC_OFS_STD_VEC, ev(17));
    wr(9'h044, 32'h0000_0000);
    wr(VIC_OFS_EOS, 32'h0000_0000);
    lines(1'b0, 1'b0);
    // fast source on a falling edge, then forced by set and clear
    wr(9'h000, 32'h0000_0020);
    fin <= 1'b0;
    repeat (6) @(posedge hclk);
    lines(1'b0, 1'b1);
    rdc(VIC_OFS_FAST_VEC, ev(0));
    lines(1'b0, 1'b0);
    wr(VIC_OFS_SET, 32'h0000_0001);
    lines(1'b0, 1'b1);
    wr(VIC_OFS_CLEAR, 32'h0000_0001);
    lines(1'b0, 1'b0);
    fin <= 1'b1;
    // rising edge on the third external pin, mode set while disabled
    wr(VIC_OFS_DISABLE, 32'h0004_0000);
    ext <= 3'h3;
    repeat (6) @(posedge hclk);
    wr(9'h048, 32'h0000_0061);
    wr(VIC_OFS_ENABLE, 32'h0004_0000);
    lines(1'b0, 1'b0);
    ext <= 3'h7;
    repeat (6) @(posedge hclk);
    lines(1'b1, 1'b0);
    rdc(VIC_OFS_STD_VEC, ev(18));
    wr(VIC_OFS_EOS, 32'h0000_0000);
    `CHK("fast count", 3, fast_cnt)
    `CHK("std count", 10, std_cnt)
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(VIC_OFS_MASK, 32'h0000_0000);
    results();
  end
endmodule // vic_ctrl_tb
